// ===== logic/rpp_pins.sv
// rmii receive/transmit pin logic with shared configuration straps
//
// Local design decisions: the Wishbone register port and the address map.
`include "rpp_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module rpp_pins
  import rpp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire rpp_word_t   rx_word_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  output logic      [1:0]  tx_dibit_o,
  output logic             tx_en_o,
  output logic             tx_tick_o,
  input  wire logic [1:0]  rxd_i,
  output logic      [1:0]  rxd_o,
  output logic             rxd_oe,
  input  wire logic        crs_dv_i,
  output logic             crs_dv_o,
  output logic             crs_dv_oe,
  input  wire logic        rx_er_i,
  output logic             rx_er_o,
  output logic             rx_er_oe,
  input  wire logic [1:0]  txd_i,
  input  wire logic        tx_en_i,
  output rpp_strap_t       strap_o,
  output logic             strap_valid_o
);

  // ==========================================
  // helpers
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  // ==========================================
  // pin synchronisers
  logic [3:0] rxp_s1_reg;
  logic [3:0] rxp_s2_reg;
  logic [2:0] txp_s1_reg;
  logic [2:0] txp_s2_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxp_s1_reg <= 4'h0;
      rxp_s2_reg <= 4'h0;
      txp_s1_reg <= 3'h0;
      txp_s2_reg <= 3'h0;
    end else begin
      rxp_s1_reg <= {crs_dv_i, rx_er_i, rxd_i};
      rxp_s2_reg <= rxp_s1_reg;
      txp_s1_reg <= {tx_en_i, txd_i};
      txp_s2_reg <= txp_s1_reg;
    end
  end

  // ==========================================
  // control register and bus request
  logic       req;
  logic       wr_fire;
  logic       ack_reg;
  logic [3:0] ctrl_reg;
  logic       restrap;
  logic       speed10;
  logic       half_dup;
  logic       loop_sel;

  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_fire  = req & ack_reg & wb_we_i & wb_sel_i[0];
  assign restrap  = wr_fire & hit(wb_adr_i, `RPP_CTRL_OFS) &
                    wb_dat_i[`RPP_CTRL_RESTRAP];
  assign speed10  = ctrl_reg[`RPP_CTRL_SPEED10];
  assign half_dup = ctrl_reg[`RPP_CTRL_HALF];
  // echo path shut off in 10 Mb/s half duplex
  assign loop_sel = ctrl_reg[`RPP_CTRL_LOOP] & ~(speed10 & half_dup);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `RPP_CTRL_RST;
    end else if (wr_fire && hit(wb_adr_i, `RPP_CTRL_OFS)) begin
      // restrap bit is a strobe, never stored
      ctrl_reg <= {1'b0, wb_dat_i[2:0]};
    end
  end

  // ==========================================
  // strap phase
  rpp_cfg_t   cfg_reg;
  logic [3:0] strap_cnt_reg;
  rpp_strap_t strap_reg;
  logic       strap_take;

  assign strap_take = (cfg_reg == RPP_CFG_STRAP) &&
                      (strap_cnt_reg == `RPP_STRAP_CYC - 4'h1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg       <= RPP_CFG_STRAP;
      strap_cnt_reg <= 4'h0;
    end else if (restrap) begin
      cfg_reg       <= RPP_CFG_STRAP;
      strap_cnt_reg <= 4'h0;
    end else begin
      case (cfg_reg)
        RPP_CFG_STRAP: begin
          // pins float long enough for pull resistors and the synchroniser
          strap_cnt_reg <= strap_cnt_reg + 4'h1;
          if (strap_take) begin
            cfg_reg <= RPP_CFG_RUN;
          end
        end
        RPP_CFG_RUN: begin
          strap_cnt_reg <= 4'h0;
        end
        default: begin
          cfg_reg <= RPP_CFG_STRAP;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= '0;
    end else if (strap_take) begin
      strap_reg.op_mode_strap_bit0   <= rxp_s2_reg[0];
      strap_reg.op_mode_strap_bit1   <= rxp_s2_reg[1];
      strap_reg.op_mode_strap_bit2   <= rxp_s2_reg[3];
      strap_reg.mgmt_addr_strap_bit0 <= rxp_s2_reg[2];
    end
  end

  assign strap_o       = strap_reg;
  assign strap_valid_o = (cfg_reg == RPP_CFG_RUN);

  // ==========================================
  // dibit rate divider
  logic [4:0] div_reg;
  logic [4:0] div_max;
  logic       tick;

  assign div_max   = speed10 ? (`RPP_DIV_10 - 5'h01) : (`RPP_DIV_100 - 5'h01);
  assign tick      = (div_reg >= div_max);
  assign tx_tick_o = tick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 5'h00;
    end else if (tick) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // ==========================================
  // transmit capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_dibit_o <= 2'h0;
      tx_en_o    <= 1'b0;
    end else if (tick) begin
      // data only counts while enable is high
      tx_en_o    <= txp_s2_reg[2];
      tx_dibit_o <= txp_s2_reg[2] ? txp_s2_reg[1:0] : 2'h0;
    end
  end

  // ==========================================
  // two-entry receive buffer
  rpp_word_t  buf_mem [0:1];
  logic       wp_reg;
  logic       rp_reg;
  logic [1:0] cnt_reg;
  rpp_word_t  in_word;
  logic       in_valid;
  logic       in_ready;
  logic       push;
  logic       pop;
  logic       out_valid;
  rpp_word_t  out_word;

  always_comb begin
    in_word = rx_word_i;
    if (loop_sel) begin
      in_word.active = txp_s2_reg[2];
      in_word.err    = 1'b0;
      in_word.dibit  = txp_s2_reg[1:0];
    end
  end

  assign in_valid   = loop_sel ? tick : rx_valid_i;
  assign in_ready   = (cnt_reg != 2'h2);
  // core stalls while the loopback path owns the buffer
  assign rx_ready_o = in_ready & ~loop_sel;
  assign push       = in_valid & in_ready;
  assign out_valid  = (cnt_reg != 2'h0);
  assign pop        = tick & out_valid & (cfg_reg == RPP_CFG_RUN);
  assign out_word   = buf_mem[rp_reg];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_mem[wp_reg] <= in_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // ==========================================
  // delimiter tracking
  logic [7:0] hist_reg;
  logic [7:0] hist_next;
  logic       sfd_reg;

  assign hist_next = {hist_reg[5:0], out_word.dibit[0], out_word.dibit[1]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_reg <= 8'h00;
      sfd_reg  <= 1'b0;
    end else if (pop) begin
      if (!out_word.active) begin
        hist_reg <= 8'h00;
        sfd_reg  <= 1'b0;
      end else begin
        hist_reg <= hist_next;
        if (hist_next == `RPP_SFD_BYTE) begin
          sfd_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // receive pins
  logic crs_next;
  logic er_next;
  logic [1:0] rxd_next;

  always_comb begin
    crs_next = 1'b0;
    er_next  = 1'b0;
    rxd_next = 2'h0;
    if (out_valid) begin
      crs_next = out_word.active;
      er_next  = out_word.active & out_word.err;
      // at 10 Mb/s the preamble is hidden from the MAC
      if (out_word.active && (!speed10 || sfd_reg)) begin
        rxd_next = out_word.dibit;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crs_dv_o <= 1'b0;
      rx_er_o  <= 1'b0;
      rxd_o    <= 2'h0;
    end else if (cfg_reg != RPP_CFG_RUN) begin
      crs_dv_o <= 1'b0;
      rx_er_o  <= 1'b0;
      rxd_o    <= 2'h0;
    end else if (tick) begin
      // an empty buffer at a slot shows an idle medium
      crs_dv_o <= crs_next;
      rx_er_o  <= er_next;
      rxd_o    <= rxd_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_oe    <= 1'b0;
      crs_dv_oe <= 1'b0;
      rx_er_oe  <= 1'b0;
    end else begin
      rxd_oe    <= (cfg_reg == RPP_CFG_RUN) & ~restrap;
      crs_dv_oe <= (cfg_reg == RPP_CFG_RUN) & ~restrap;
      rx_er_oe  <= (cfg_reg == RPP_CFG_RUN) & ~restrap;
    end
  end

  // ==========================================
  // bus answer
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h0;
    if (hit(wb_adr_i, `RPP_CTRL_OFS)) begin
      rd_next[3:0] = ctrl_reg;
    end else if (hit(wb_adr_i, `RPP_STAT_OFS)) begin
      rd_next[`RPP_STAT_MODE_LSB+:3] = {strap_reg.op_mode_strap_bit2,
        strap_reg.op_mode_strap_bit1, strap_reg.op_mode_strap_bit0};
      rd_next[`RPP_STAT_ADDR0] = strap_reg.mgmt_addr_strap_bit0;
      rd_next[`RPP_STAT_VALID] = strap_valid_o;
      rd_next[`RPP_STAT_SFD]   = sfd_reg;
      rd_next[`RPP_STAT_CRS]   = crs_dv_o;
      rd_next[`RPP_STAT_FULL]  = ~in_ready;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) begin
        wb_dat_o <= wb_we_i ? 32'h0 : rd_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  strap_float_a: assert property (
    cfg_reg == RPP_CFG_STRAP |-> !rxd_oe && !crs_dv_oe && !rx_er_oe)
    else $error("strap pin driven during strap phase");

  strap_mode_a: assert property (
    strap_take |=> {strap_o.op_mode_strap_bit2, strap_o.op_mode_strap_bit1,
      strap_o.op_mode_strap_bit0} == {$past(rxp_s2_reg[3]), $past(rxp_s2_reg[1:0])})
    else $error("mode straps not captured");

  strap_addr_a: assert property (
    strap_take |=> strap_o.mgmt_addr_strap_bit0 == $past(rxp_s2_reg[2]))
    else $error("address strap not captured");

  strap_hold_a: assert property (
    cfg_reg == RPP_CFG_RUN && !restrap |=> $stable(strap_reg))
    else $error("straps changed outside capture");

  strap_len_a: assert property (
    $rose(cfg_reg == RPP_CFG_STRAP) |-> (cfg_reg == RPP_CFG_STRAP)[*4] ##1
      cfg_reg == RPP_CFG_RUN)
    else $error("strap phase length wrong");

  sfd_hide_a: assert property (
    speed10 && !sfd_reg && tick && cfg_reg == RPP_CFG_RUN |=> rxd_o == 2'h0)
    else $error("data shown before delimiter");

  crs_follow_a: assert property (
    pop |=> crs_dv_o == $past(out_word.active))
    else $error("carrier sense does not follow medium");

  err_follow_a: assert property (
    pop |=> rx_er_o == $past(out_word.active & out_word.err))
    else $error("receive error lost");

  data_path_a: assert property (
    pop && !speed10 && out_word.active |=> rxd_o == $past(out_word.dibit))
    else $error("receive dibit wrong");

  no_echo_a: assert property (
    speed10 && half_dup |-> !loop_sel && in_valid == rx_valid_i)
    else $error("echo path open in half duplex");

  buf_full_a: assert property (
    cnt_reg == 2'h2 |-> !rx_ready_o)
    else $error("buffer accepts when full");

  ack_len_a: assert property (
    req && !ack_reg |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");

  sfd_seen_c: cover property (speed10 && $rose(sfd_reg));
  buf_fill_c: cover property (cnt_reg == 2'h2 && rx_valid_i);
  restrap_c: cover property (restrap ##[1:8] cfg_reg == RPP_CFG_RUN);
  rx_err_c: cover property (rx_er_o && crs_dv_o);

endmodule : rpp_pins

`default_nettype wire

// ===== inc/rpp_regs.svh
// register offsets, field positions, reset values and counts of the rmii pin block
`ifndef RPP_REGS_SVH
`define RPP_REGS_SVH

// ==========================================
// register map (byte addresses)
`define RPP_CTRL_OFS     8'h00
`define RPP_STAT_OFS     8'h04

// ==========================================
// control fields
`define RPP_CTRL_SPEED10 0
`define RPP_CTRL_HALF    1
`define RPP_CTRL_LOOP    2
`define RPP_CTRL_RESTRAP 3
`define RPP_CTRL_RST     4'h0

// ==========================================
// status fields
`define RPP_STAT_MODE_LSB 0
`define RPP_STAT_ADDR0    3
`define RPP_STAT_VALID    4
`define RPP_STAT_SFD      5
`define RPP_STAT_CRS      6
`define RPP_STAT_FULL     7

// ==========================================
// timing counts and constants
`define RPP_STRAP_CYC    4'h4
`define RPP_DIV_100      5'h02
`define RPP_DIV_10       5'h14
`define RPP_SFD_BYTE     8'hab

`endif

// ===== inc/rpp_pkg.sv
// types shared by the rmii pin block
package rpp_pkg;

  // ==========================================
  // one receive dibit slot
  typedef struct packed {
    logic       active;
    logic       err;
    logic [1:0] dibit;
  } rpp_word_t;

  // ==========================================
  // captured configuration straps
  typedef struct packed {
    logic op_mode_strap_bit2;
    logic op_mode_strap_bit1;
    logic op_mode_strap_bit0;
    logic mgmt_addr_strap_bit0;
  } rpp_strap_t;

  typedef enum logic [1:0] {
    RPP_CFG_STRAP = 2'b01,
    RPP_CFG_RUN   = 2'b10
  } rpp_cfg_t;

endpackage : rpp_pkg

// ===== tb/rpp_mac_model.sv
// behavioural mac at the far side of the rmii pins
`timescale 1ns/10ps
`default_nettype none

module rpp_mac_model (
  input  wire logic       sys_clk,
  input  wire logic       tick,
  input  wire logic [1:0] rxd,
  input  wire logic       crs_dv,
  input  wire logic       rx_er,
  output logic      [1:0] txd,
  output logic            tx_en
);
  logic       tick_reg;
  logic [3:0] got[$];

  initial begin
    txd      = 2'h0;
    tx_en    = 1'b0;
    tick_reg = 1'b0;
  end

  // ==========================================
  // receive: pins settle one cycle after the slot tick
  always @(posedge sys_clk) begin
    tick_reg <= tick;
    if (tick_reg && crs_dv === 1'b1)
      got.push_back({crs_dv, rx_er, rxd});
  end

  // ==========================================
  // transmit: idle data is driven inverted, not left at the last value
  task automatic send(input logic en, input logic [1:0] d);
    @(posedge sys_clk);
    tx_en <= en;
    txd   <= en ? d : ~d;
  endtask : send
endmodule : rpp_mac_model
`default_nettype wire

// ===== tb/tb_rpp_pins.sv
// self-checking bench for the rmii pin block
`timescale 1ns/10ps
`default_nettype none

module tb_rpp_pins;
  import rpp_pkg::*;
  logic        sys_clk, rst_n, wb_cyc, wb_stb, wb_we, rx_valid, rx_ready_o;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o, q;
  logic        wb_ack_o, tx_en_o, tx_tick_o, crs_dv_i, crs_dv_o, crs_dv_oe;
  logic        rx_er_i, rx_er_o, rx_er_oe, tx_en_i, rxd_oe, strap_valid_o;
  logic [1:0]  tx_dibit_o, rxd_i, rxd_o, txd_i, d;
  rpp_word_t   rx_word, w;
  rpp_strap_t  strap_o, s;
  logic [4:0]  exp_q[$];
  int          errors, comparisons, seed, i;

  // ==========================================
  // pin levels: straps come from external resistors while undriven
  assign rxd_i    = rxd_oe ? rxd_o : {s.op_mode_strap_bit1, s.op_mode_strap_bit0};
  assign crs_dv_i = crs_dv_oe ? crs_dv_o : s.op_mode_strap_bit2;
  assign rx_er_i  = rx_er_oe ? rx_er_o : s.mgmt_addr_strap_bit0;

  rpp_pins rpp_pins_inst (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_word_i(rx_word),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready_o), .tx_dibit_o(tx_dibit_o),
    .tx_en_o(tx_en_o), .tx_tick_o(tx_tick_o), .rxd_i(rxd_i), .rxd_o(rxd_o),
    .rxd_oe(rxd_oe), .crs_dv_i(crs_dv_i), .crs_dv_o(crs_dv_o), .crs_dv_oe(crs_dv_oe),
    .rx_er_i(rx_er_i), .rx_er_o(rx_er_o), .rx_er_oe(rx_er_oe), .txd_i(txd_i),
    .tx_en_i(tx_en_i), .strap_o(strap_o), .strap_valid_o(strap_valid_o));

  rpp_mac_model rpp_mac_model_inst (.sys_clk(sys_clk), .tick(tx_tick_o), .rxd(rxd_i),
    .crs_dv(crs_dv_i), .rx_er(rx_er_i), .txd(txd_i), .tx_en(tx_en_i));

  always #5 sys_clk = ~sys_clk;

  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      finish_test();
    end
  endtask : bound

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= dat;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    bound(n, 50);
  endtask : wb

  task automatic ticks(input int k);
    int n;
    for (n = 0; k > 0 && n < 2000; n++) begin
      @(posedge sys_clk);
      if (tx_tick_o === 1'b1)
        k--;
    end
    bound(n, 2000);
  endtask : ticks

  // caller stands just after an edge, so back-to-back pushes keep valid high
  task automatic push(input rpp_word_t x);
    int n;
    rx_word  <= x;
    rx_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rx_ready_o !== 1'b1 && n < 400);
    bound(n, 400);
  endtask : push

  function automatic logic [4:0] rx_exp(input rpp_word_t x, input logic hold);
    return {2'b11, x.active & x.err, hold ? 2'h0 : x.dibit};
  endfunction : rx_exp

  task automatic drain;
    logic [4:0] e;
    rx_valid <= 1'b0;
    ticks(4);
    check("rx count", rpp_mac_model_inst.got.size(), exp_q.size());
    while (exp_q.size() > 0 && rpp_mac_model_inst.got.size() > 0) begin
      e = exp_q.pop_front();
      if (e[4])
        check("rx pins", rpp_mac_model_inst.got[0], e[3:0]);
      void'(rpp_mac_model_inst.got.pop_front());
    end
    rpp_mac_model_inst.got.delete();
    exp_q.delete();
  endtask : drain

  task automatic wait_strap;
    for (int n = 0; n < 20 && strap_valid_o !== 1'b1; n++)
      @(posedge sys_clk);
    check("strap valid", strap_valid_o, 1);
    check("straps", strap_o, s);
    wb(1'b0, 8'h04, 0);
    check("status", q[4:0], {1'b1, s[0], s[3:1]});
    repeat (3) @(posedge sys_clk);
    check("oe", {rxd_oe, crs_dv_oe, rx_er_oe}, 3'h7);
  endtask : wait_strap

  initial begin
    seed = 86;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, rx_valid} = 4'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    rx_word = '0;
    s = rpp_strap_t'($random(seed));
    repeat (12) @(posedge sys_clk);
    check("reset pins", {rxd_oe, crs_dv_oe, rx_er_oe, strap_valid_o}, 0);
    rst_n <= 1'b1;
    wait_strap();
    wb(1'b0, 8'h00, 0);
    check("ctrl reset", q, 0);
    wb(1'b1, 8'h08, 32'hffffffff);
    wb(1'b0, 8'h08, 0);
    check("unmapped", q, 0);
    // 10 Mb/s half duplex: preamble, delimiter, then data
    wb(1'b1, 8'h00, 32'h3);
    ticks(1);
    // crs_dv shows its strap level until the pins are driven, so drop those samples
    rpp_mac_model_inst.got.delete();
    for (i = 0; i < 14; i++) begin
      w = (i < 7) ? 4'b1001 : (i == 7) ? 4'b1011 : {1'b1, 3'($random(seed))};
      exp_q.push_back(rx_exp(w, i < 8));
      push(w);
      if (i == 1) begin
        rx_valid <= 1'b0;
        wb(1'b0, 8'h04, 0);
        check("full", q[7], 1);
        check("ready", rx_ready_o, 0);
      end
    end
    push(4'h0);
    drain();
    wb(1'b1, 8'h00, 32'h0);
    for (i = 0; i < 16; i++) begin
      w = {1'b1, 3'($random(seed))};
      exp_q.push_back(rx_exp(w, 1'b0));
      push(w);
    end
    drain();
    for (i = 0; i < 8; i++) begin
      d = 2'($random(seed));
      rpp_mac_model_inst.send(i[0] | i[2], d);
      ticks(3);
      check("tx en", tx_en_o, i[0] | i[2]);
      check("tx data", tx_dibit_o, (i[0] | i[2]) ? d : 2'h0);
    end
    wb(1'b1, 8'h00, 32'h4);
    ticks(6);
    check("loop ready", rx_ready_o, 0);
    check("loop echo", rpp_mac_model_inst.got.size() != 0, 1);
    rpp_mac_model_inst.send(1'b0, 2'h0);
    wb(1'b1, 8'h00, 32'h7);
    ticks(4);
    rpp_mac_model_inst.got.delete();
    rpp_mac_model_inst.send(1'b1, 2'h1);
    ticks(6);
    check("no echo", rpp_mac_model_inst.got.size(), 0);
    rpp_mac_model_inst.send(1'b0, 2'h0);
    s = ~s;
    wb(1'b1, 8'h00, 32'h8);
    repeat (2) @(posedge sys_clk);
    check("restrap oe", {rxd_oe, crs_dv_oe, rx_er_oe}, 0);
    wait_strap();
    // a second system reset must take fresh straps as well
    s = 4'($random(seed));
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("reset pins", {rxd_oe, crs_dv_oe, rx_er_oe, strap_valid_o}, 0);
    rst_n <= 1'b1;
    wait_strap();
    finish_test();
  end
endmodule : tb_rpp_pins
`default_nettype wire
